// File: tb/sac_host.sv
`default_nettype none

// Host model: drives the select, address and shift pins, reads the result pin.
module sac_host (
    // Clock.
    input wire logic clock,
    // Pins to and from the device.
    output logic cs_n,
    output logic addr_in,
    output logic io_clk,
    output logic sys_clk,
    input wire logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] div_q; // Divider for the free conversion clock.
    logic free_q; // The conversion clock runs free from the divider.

    // Idle pin levels at time zero.
    initial begin
        cs_n = 1'b1;
        addr_in = 1'b0;
        io_clk = 1'b0;
        sys_clk = 1'b0;
        div_q = 3'h0;
        free_q = 1'b1;
    end

    // Conversion clock runs free at 40 ns, unrelated to the shift clock.
    always @(posedge clock) begin
        div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
        if (div_q == 3'h4 && free_q) begin
            sys_clk <= ~sys_clk;
        end
    end

    // Moves the select pin, then leaves time for the filter to act.
    task automatic sel(input logic v);
        cs_n <= v;
        repeat (40) @(posedge clock);
    endtask : sel

    // One ten-cycle frame at 48 ns; each bit is read just before a rise.
    task automatic frame(input logic [3:0] addr, output logic [9:0] rd);
        for (int k = 0; k < 10; k++) begin
            addr_in <= (k < 4) ? addr[3 - k] : 1'b0;
            repeat (6) @(posedge clock);
            rd[9 - k] = pin;
            io_clk <= 1'b1;
            repeat (6) @(posedge clock);
            io_clk <= 1'b0;
        end
    endtask : frame

    // Shared clock on both pins: two select cycles, ten valid cycles, then conversion.
    task automatic frame_common(input logic [3:0] addr, output logic [9:0] rd);
        free_q <= 1'b0;
        @(posedge clock);
        sys_clk <= 1'b0;
        repeat (6) @(posedge clock);
        cs_n <= 1'b0;
        for (int k = -2; k < 10; k++) begin
            addr_in <= (k >= 0 && k < 4) ? addr[3 - k] : 1'b0;
            repeat (6) @(posedge clock);
            if (k >= 0) begin
                rd[9 - k] = pin;
            end
            io_clk <= 1'b1;
            sys_clk <= 1'b1;
            repeat (6) @(posedge clock);
            io_clk <= 1'b0;
            sys_clk <= 1'b0;
        end
        // Select goes high after the twelfth clock, before the next rise.
        repeat (3) @(posedge clock);
        cs_n <= 1'b1;
        // The shared clock keeps running to finish the conversion.
        for (int k = 0; k < 46; k++) begin
            repeat (3) @(posedge clock);
            io_clk <= 1'b1;
            sys_clk <= 1'b1;
            repeat (6) @(posedge clock);
            io_clk <= 1'b0;
            sys_clk <= 1'b0;
            repeat (3) @(posedge clock);
        end
        free_q <= 1'b1;
    endtask : frame_common
endmodule : sac_host

`default_nettype wire

// File: tb/serial_adc_control_sequencer_test.sv
`default_nettype none

module serial_adc_control_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sac_pkg::*;

    logic clock;
    logic rst_n;
    logic [9:0] analog_code; // Stand-in for the sampled level.
    wire logic cs_n, addr_in, io_clk, sys_clk, dout_o, dout_oe, sampling_o, busy_o;
    sac_mux_s mux_o;
    wire logic pin = dout_oe ? dout_o : ~dout_o; // Released pin shows the inverse.
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int smp_cyc = 0; // Clock edges seen with sampling high.

    sac_top u_sac_top (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .addr_in(addr_in),
        .io_clk(io_clk), .sys_clk(sys_clk), .dout_o(dout_o), .dout_oe(dout_oe),
        .analog_code(analog_code), .mux_o(mux_o), .sampling_o(sampling_o),
        .busy_o(busy_o));
    sac_host u_sac_host (.clock(clock), .cs_n(cs_n), .addr_in(addr_in),
        .io_clk(io_clk), .sys_clk(sys_clk), .pin(pin));

    // Clock at 4 ns.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Hang guard.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            final_report();
        end
    end

    // Counts how long each sample phase lasts.
    always @(posedge clock) begin
        if (sampling_o === 1'b1) begin
            smp_cyc <= smp_cyc + 1;
        end
    end

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // Compares one value.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Expected selection for an address code.
    function automatic sac_mux_s mux_exp(input logic [3:0] a);
        return '{a, a < 4'hB, a == 4'hB};
    endfunction : mux_exp

    // One frame: reads the previous result and checks selection, sampling and hold.
    task automatic run(input logic [3:0] a, input logic [9:0] v, input logic [9:0] exp);
        logic [9:0] rd;
        int s0;
        analog_code <= v;
        s0 = smp_cyc;
        u_sac_host.frame(a, rd);
        check(16'(rd), 16'(exp));
        check(16'(mux_o), 16'(mux_exp(a)));
        repeat (6) @(posedge clock);
        check(16'(busy_o), 16'h0001);
        check(16'(smp_cyc - s0), 16'h0048);
    endtask : run

    // Waits for the conversion to end.
    task automatic wait_idle();
        for (int i = 0; i < 600 && busy_o !== 1'b0; i++) begin
            @(posedge clock);
        end
        check(16'(busy_o), 16'h0000);
    endtask : wait_idle

    // Select high: a frame must leave no trace.
    task automatic t_ignored();
        logic [9:0] rd;
        u_sac_host.frame(4'h5, rd);
        check(16'(dout_oe), 16'h0000);
        check(16'({mux_o, busy_o}), 16'h0000);
    endtask : t_ignored

    // Back-to-back frames, codes, early restart, select abort.
    task automatic t_frames();
        u_sac_host.sel(1'b0);
        check(16'(dout_oe), 16'h0001);
        run(4'h3, 10'h2A5, 10'h000);
        wait_idle();
        run(4'hB, 10'h15A, 10'h2A5);
        wait_idle();
        run(4'hC, 10'h3C3, 10'h15A);
        run(4'h1, 10'h0F0, 10'h15A);
        wait_idle();
        run(4'h2, 10'h111, 10'h0F0);
        u_sac_host.sel(1'b1);
        check(16'(dout_oe), 16'h0000);
        u_sac_host.sel(1'b0);
        check(16'(busy_o), 16'h0000);
        run(4'h4, 10'h222, 10'h0F0);
        wait_idle();
        u_sac_host.sel(1'b1);
        u_sac_host.sel(1'b0);
        run(4'hF, 10'h301, 10'h222);
    endtask : t_frames

    // Common clock: filter cycles shift nothing, the shared clock converts.
    task automatic t_common();
        logic [9:0] rd;
        int s0;
        wait_idle();
        u_sac_host.sel(1'b1);
        analog_code <= 10'h0AB;
        s0 = smp_cyc;
        u_sac_host.frame_common(4'h7, rd);
        check(16'(rd), 16'h0301);
        check(16'(mux_o), 16'(mux_exp(4'h7)));
        check(16'(smp_cyc - s0), 16'h0048);
        check(16'(busy_o), 16'h0000);
        u_sac_host.sel(1'b0);
        run(4'h0, 10'h1FF, 10'h0AB);
    endtask : t_common

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        analog_code = 10'h000;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_ignored();
        t_frames();
        t_common();
        final_report();
    end
endmodule : serial_adc_control_sequencer_test

`default_nettype wire

// File: verilog/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// ----------------------------------------------------------------------
// Sequence counts
// ----------------------------------------------------------------------
`define SAC_FILT_RISES 2'd2
`define SAC_ADDR_EDGES 4'd4
`define SAC_SAMPLE_EDGE 4'd4
`define SAC_HOLD_EDGE 4'd10
`define SAC_CONV_LAST 6'd43

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define SAC_SELF_TEST_CODE 4'hB
`define SAC_RESULT_RST 10'h000

`endif

// File: verilog/sac_pkg.sv
`default_nettype none

package sac_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------

    // Control sequence phase.
    typedef enum logic [1:0] {SAC_IDLE, SAC_FILTER, SAC_ACTIVE} sac_phase_e;

    // Multiplexer selection handed to the analog front end.
    typedef struct packed {
        logic [3:0] chan;       // Latched channel address.
        logic ext_valid;        // An external input is selected.
        logic self_test_channel; // The internal test voltage is selected.
    } sac_mux_s;

    // Entire state of the sequencer.
    typedef struct packed {
        logic cs_s1, cs_s2, io_s1, io_s2, io_p, ad_s1, ad_s2, sy_s1, sy_s2, sy_p;
        sac_phase_e phase;
        logic [1:0] filt_cnt;
        logic [3:0] bit_cnt;
        logic [3:0] addr_sr;
        logic [9:0] shift;
        logic sampling;
        logic busy;
        logic [5:0] conv_cnt;
        logic [9:0] held;
        logic [9:0] result;
        sac_mux_s mux;
    } sac_state_s;

endpackage : sac_pkg

`default_nettype wire

// File: verilog/sac_top.sv
`include "sac_defs.svh"
`default_nettype none

module sac_top (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Serial pins from the host.
    input wire logic cs_n,
    input wire logic addr_in,
    input wire logic io_clk,
    input wire logic sys_clk,
    // Serial result pin, two signals: data and enable.
    output logic dout_o,
    output logic dout_oe,
    // Analog front end.
    input wire logic [9:0] analog_code,
    output sac_pkg::sac_mux_s mux_o,
    output logic sampling_o,
    output logic busy_o
);
    import sac_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Decodes a channel address into the multiplexer selection.
    function automatic sac_mux_s mux_decode(input logic [3:0] code);
        sac_mux_s m;
        m.chan = code;
        m.ext_valid = (code < `SAC_SELF_TEST_CODE);
        m.self_test_channel = (code == `SAC_SELF_TEST_CODE);
        return m;
    endfunction : mux_decode

    sac_state_s q; // Registered state.
    sac_state_s d; // Next state.
    logic cs_hi; // Synchronised select level.
    logic io_rise; // Shift clock rising edge.
    logic io_fall; // Shift clock falling edge.
    logic sy_rise; // Conversion clock rising edge.
    logic sy_fall; // Conversion clock falling edge.
    logic recog; // Select recognised in this cycle.

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Synchronises the pins, finds edges and steps the sequence.
    always_comb begin
        d = q;
        // Two flip-flops per pin before any logic looks at it.
        d.cs_s1 = cs_n;
        d.cs_s2 = q.cs_s1;
        d.io_s1 = io_clk;
        d.io_s2 = q.io_s1;
        d.io_p = q.io_s2;
        d.ad_s1 = addr_in;
        d.ad_s2 = q.ad_s1;
        d.sy_s1 = sys_clk;
        d.sy_s2 = q.sy_s1;
        d.sy_p = q.sy_s2;
        cs_hi = q.cs_s2;
        io_rise = q.io_s2 & ~q.io_p;
        io_fall = ~q.io_s2 & q.io_p;
        sy_rise = q.sy_s2 & ~q.sy_p;
        sy_fall = ~q.sy_s2 & q.sy_p;
        recog = 1'b0;
        // Conversion steps on conversion clock rises; select high leaves it running, recognition aborts it.
        if (q.busy && sy_rise) begin
            d.conv_cnt = q.conv_cnt + 6'd1;
            if (q.conv_cnt == `SAC_CONV_LAST) begin
                d.busy = 1'b0;
                d.result = q.held;
                // A sequence already under way keeps showing the old word.
                if (q.bit_cnt == 4'd0) begin
                    d.shift = q.held;
                end
            end
        end
        case (q.phase)
            SAC_IDLE: begin
                // Select high: shift clock and address are ignored.
                if (!cs_hi) begin
                    d.phase = SAC_FILTER;
                    d.filt_cnt = 2'd0;
                end
            end
            SAC_FILTER: begin
                // Shift clock edges here shift nothing.
                if (cs_hi) begin
                    d.phase = SAC_IDLE;
                end else if (sy_rise && q.filt_cnt != `SAC_FILT_RISES) begin
                    d.filt_cnt = q.filt_cnt + 2'd1;
                end else if (sy_fall && q.filt_cnt == `SAC_FILT_RISES) begin
                    recog = 1'b1;
                end
            end
            SAC_ACTIVE: begin
                if (cs_hi) begin
                    // Raising select leaves a running conversion alone.
                    d.phase = SAC_IDLE;
                    d.bit_cnt = 4'd0;
                    d.sampling = 1'b0;
                end else if (io_rise && q.bit_cnt < `SAC_ADDR_EDGES) begin
                    d.addr_sr = {q.addr_sr[2:0], q.ad_s2};
                end else if (io_fall) begin
                    d.shift = {q.shift[8:0], 1'b0};
                    d.bit_cnt = q.bit_cnt + 4'd1;
                    if (q.bit_cnt + 4'd1 == `SAC_SAMPLE_EDGE) begin
                        d.mux = mux_decode(q.addr_sr);
                        d.sampling = 1'b1;
                    end
                    if (q.bit_cnt + 4'd1 == `SAC_HOLD_EDGE) begin
                        // Hold and restart, dropping any older conversion.
                        d.sampling = 1'b0;
                        d.held = analog_code;
                        d.busy = 1'b1;
                        d.conv_cnt = 6'd0;
                        d.bit_cnt = 4'd0;
                        // A conversion ending in this very cycle is already the newest word.
                        d.shift = d.result;
                    end
                end
            end
            default: begin
                d.phase = SAC_IDLE;
            end
        endcase
        // Recognition resets the sequence and aborts a conversion.
        if (recog) begin
            d.phase = SAC_ACTIVE;
            d.bit_cnt = 4'd0;
            d.shift = q.result;
            d.busy = 1'b0;
            d.sampling = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Registers the whole state; the select synchronisers idle high after reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
            q.phase <= SAC_IDLE;
            q.result <= `SAC_RESULT_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops, except the enable, decoded from the phase.
    assign dout_o = q.shift[9];
    assign dout_oe = (q.phase == SAC_ACTIVE);
    assign mux_o = q.mux;
    assign sampling_o = q.sampling;
    assign busy_o = q.busy;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_float;
        q.cs_s2 |=> !dout_oe;
    endproperty
    a_float: assert property (p_float) else $error("output driven with select high");

    property p_recog;
        !dout_oe && !q.cs_s2 && q.phase == SAC_FILTER && sy_fall && q.filt_cnt == 2'd2
            |=> dout_oe && dout_o == $past(q.result[9]);
    endproperty
    a_recog: assert property (p_recog) else $error("select not recognised");

    property p_early;
        q.phase == SAC_FILTER && q.filt_cnt != 2'd2 |=> !dout_oe;
    endproperty
    a_early: assert property (p_early) else $error("select accepted early");

    property p_addr;
        q.phase == SAC_ACTIVE && !q.cs_s2 && io_rise && q.bit_cnt < 4'd4
            |=> q.addr_sr == {$past(q.addr_sr[2:0]), $past(q.ad_s2)};
    endproperty
    a_addr: assert property (p_addr) else $error("address bit missed");

    property p_filt_noshift;
        q.phase == SAC_FILTER |=> q.addr_sr == $past(q.addr_sr);
    endproperty
    a_filt_noshift: assert property (p_filt_noshift) else $error("address shifted early");

    property p_shift;
        q.phase == SAC_ACTIVE && !q.cs_s2 && io_fall && q.bit_cnt < 4'd9
            |=> dout_o == $past(q.shift[8]);
    endproperty
    a_shift: assert property (p_shift) else $error("result bit not shifted");

    property p_sample;
        q.phase == SAC_ACTIVE && !q.cs_s2 && io_fall && q.bit_cnt == 4'd3
            |=> sampling_o && mux_o.chan == $past(q.addr_sr);
    endproperty
    a_sample: assert property (p_sample) else $error("sampling not started");

    property p_hold;
        q.phase == SAC_ACTIVE && !q.cs_s2 && io_fall && q.bit_cnt == 4'd9
            |=> busy_o && !sampling_o && q.conv_cnt == 6'd0 && q.held == $past(analog_code);
    endproperty
    a_hold: assert property (p_hold) else $error("hold not started");

    property p_done;
        q.busy && sy_rise && q.conv_cnt == 6'd43 && !recog
            && !(q.phase == SAC_ACTIVE && !q.cs_s2 && io_fall && q.bit_cnt == 4'd9)
            |=> !busy_o && q.result == q.held;
    endproperty
    a_done: assert property (p_done) else $error("conversion end wrong");

    property p_abort;
        recog |=> !busy_o && q.result == $past(q.result);
    endproperty
    a_abort: assert property (p_abort) else $error("conversion not aborted");

    property p_mux;
        // The all-zero reset selection is no decode result and is left out.
        mux_o != '0 |-> mux_o.self_test_channel == (mux_o.chan == 4'hB)
            && mux_o.ext_valid == (mux_o.chan < 4'hB);
    endproperty
    a_mux: assert property (p_mux) else $error("channel decode wrong");

endmodule : sac_top

`default_nettype wire
